// ===== eis_partner.sv
module eis_partner (
   input  wire logic       i_sys_clk,
   input  wire logic       i_shutdown_req,
   input  wire logic       i_stall_cmd,
   input  wire logic [3:0] i_ack_delay,
   output logic            o_shutdown_ack,
   output logic            o_hit,
   output logic            o_hit_modified
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_q = 4'h0;
   // both lines together ask for a stall, holding them extends it
   assign o_hit          = i_stall_cmd;
   assign o_hit_modified = i_stall_cmd;
   // a slow chipset is modelled by a longer acknowledge delay
   always_ff @(posedge i_sys_clk) begin
      o_shutdown_ack <= i_shutdown_req && !o_shutdown_ack
                        && wait_q == i_ack_delay;
      wait_q <= (i_shutdown_req && !o_shutdown_ack) ? wait_q + 4'h1 : 4'h0;
   end
endmodule

// ===== eis_pkg.sv
package eis_pkg;
   // reset values of the sideband outputs
   localparam logic       RST_ERR_OUT   = 1'b0;
   localparam logic       RST_INTERNAL_ERROR_OUT      = 1'b0;
   localparam logic       RST_SNOOP     = 1'b0;
   // synchroniser depth for pin inputs
   localparam int         SYNC_STAGES   = 2;
   // cycles the soft-init sequencer spends clearing integer state
   localparam logic [3:0] INIT_CLR_CYC  = 4'h4;
   localparam int         INT_REGS      = 8;
   localparam int         REG_W         = 32;
   localparam logic [REG_W-1:0] RST_INT_REG = 32'h00000000;

   typedef enum logic [2:0] {
      EIS_RUN   = 3'b001,
      EIS_CLEAR = 3'b010,
      EIS_HOLD  = 3'b100
   } eis_init_t;
endpackage

// ===== eis_sync.sv
module eis_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_nrst,
   // async in, synchronous out
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

// ===== eis_top.sv
// Overview of operation
// RULE1: with stop-clock idle, the error/break output shows an unmasked fp error.
// RULE2: with stop-clock active, the output shows a pending break event.
// RULE3: a snoop stall is requested by driving hit and hit-modified together.
// RULE4: a stall is extended by driving both again; both together from others is a stall.
// RULE5: the internal error output rises on an internal error.
// RULE6: the internal error output stays high until hard reset.
// RULE7: an internal error also requests one shutdown bus transaction.
// RULE8: while ignore-numeric-error is high, pending numeric errors are ignored.
// RULE9: otherwise a noncontrol fp instruction after an fp error raises an exception.
// RULE10: ignore-numeric-error has no effect when the numeric error enable bit is set.
// RULE11: system logic holds ignore-numeric-error valid by target ready of the io write.
// RULE12: soft init clears integer registers and leaves caches and fp registers alone.
// RULE13: after soft init, execution restarts at the configured reset vector.
// RULE14: snoop requests are still serviced while soft init is held.
// RULE15: soft init is an asynchronous input, synchronised before use.
// RULE16: soft init seen active at hard reset release selects built-in self-test.
// RULE17: the error/break output meaning follows the synchronised stop-clock level.
module eis_top
   import eis_pkg::*;
#(
   parameter int NREG = eis_pkg::INT_REGS,
   parameter int W    = eis_pkg::REG_W
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_nrst,
   // async pins, active high here
   input  wire logic         i_stop_clock_request,
   input  wire logic         i_ignore_numeric_error_in,
   input  wire logic         i_soft_init,
   // core events, same clock
   input  wire logic         i_fp_error,
   input  wire logic         i_fp_error_masked,
   input  wire logic         i_fp_error_clear,
   input  wire logic         i_break_pending,
   input  wire logic         i_internal_error,
   input  wire logic         i_numeric_error_enable_bit,
   input  wire logic         i_fp_noncontrol_issue,
   input  wire logic [W-1:0] i_reset_vector,
   input  wire logic         i_shutdown_ack,
   // snoop
   input  wire logic         i_snoop_req,
   input  wire logic         i_snoop_stall_need,
   input  wire logic         i_snoop_hit,
   input  wire logic         i_snoop_hit_modified,
   input  wire logic         i_snoop_hit_in,
   input  wire logic         i_snoop_hit_modified_in,
   // integer register write port
   input  wire logic         i_reg_we,
   input  wire logic [$clog2(NREG)-1:0] i_reg_sel,
   input  wire logic [W-1:0] i_reg_wdata,
   // outputs
   output logic              o_fp_error_break_event_out,
   output logic              o_internal_error_out,
   output logic              o_shutdown_req,
   output logic              o_fp_exception,
   output logic              o_fp_continue,
   output logic              o_snoop_hit,
   output logic              o_snoop_hit_modified,
   output logic              o_snoop_stall_seen,
   output logic              o_snoop_serviced,
   output logic              o_init_busy,
   output logic              o_restart,
   output logic [W-1:0]      o_restart_pc,
   output logic              o_bist_run,
   output logic [NREG*W-1:0] o_int_regs
);
   logic       stop_clock_request_s;
   logic       ignore_numeric_error_in_s;
   logic       init_s;
   logic       fp_pend_q,  fp_pend_d;
   logic       internal_error_out_q;
   logic       shut_q;
   logic       ferr_q;
   logic       hit_q, snoop_hit_modified_q;
   logic       init_prev_q;
   logic       rst_prev_q;
   logic       bist_q;
   logic       srv_q;
   logic       rest_q;
   logic [W-1:0] pc_q;
   logic [3:0] cnt_q;
   eis_init_t  st_q, st_d;

   // syncs keep running in reset so the soft-init strap is already
   // settled at the first edge after release
   eis_sync #(.W(3)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (1'b1),
      .i_async   ({i_stop_clock_request, i_ignore_numeric_error_in,
                   i_soft_init}),
      .o_sync    ({stop_clock_request_s, ignore_numeric_error_in_s, init_s})  // RULE15
   );

   // numeric error handling
   wire fp_unmasked = i_fp_error & ~i_fp_error_masked;
   // set beats clear so an error in the clear cycle survives
   assign fp_pend_d = fp_unmasked | (fp_pend_q & ~i_fp_error_clear);
   // ne set: native exception, ignore pin is out of the picture
   wire ignore_ok  = ignore_numeric_error_in_s & ~i_numeric_error_enable_bit;  // RULE10
   wire take_exc   = i_fp_noncontrol_issue & fp_pend_q & ~ignore_ok; // RULE9
   wire go_on      = i_fp_noncontrol_issue & ~take_exc;      // RULE8
   // output meaning chosen by synced stop-clock level
   wire ferr_d     = stop_clock_request_s ? i_break_pending              // RULE2 RULE17
                              : fp_pend_d;                   // RULE1

   // snoop: stall drives both lines together, re-driven to extend
   wire stall_drv  = i_snoop_req & i_snoop_stall_need;      // RULE3 RULE4
   wire hit_d      = stall_drv | (i_snoop_req & i_snoop_hit);
   wire snoop_hit_modified_d     = stall_drv | (i_snoop_req & i_snoop_hit_modified);
   wire stall_in   = i_snoop_hit_in & i_snoop_hit_modified_in; // RULE4

   // soft-init edge and bist strap at reset release
   wire init_rise  = init_s & ~init_prev_q;

   always_comb begin
      st_d = st_q;
      case (st_q)
         EIS_RUN:   if (init_rise) st_d = EIS_CLEAR;
         EIS_CLEAR: if (cnt_q == INIT_CLR_CYC - 4'h1) st_d = EIS_HOLD;
         EIS_HOLD:  if (!init_s) st_d = EIS_RUN;
         default:   st_d = EIS_RUN;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         st_q <= EIS_RUN;
         cnt_q <= 4'h0;
         init_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= (st_q == EIS_CLEAR) ? cnt_q + 4'h1 : 4'h0;
         init_prev_q <= init_s;
      end
   end

   // integer registers only; caches and fp state live elsewhere
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_reg
         logic [W-1:0] r_q;
         always_ff @(posedge i_sys_clk) begin
            if (!i_nrst || st_q == EIS_CLEAR) begin
               r_q <= RST_INT_REG;  // RULE12
            end else if (i_reg_we && i_reg_sel == g) begin
               r_q <= i_reg_wdata;
            end
         end
         assign o_int_regs[g*W +: W] = r_q;
      end
   endgenerate

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         fp_pend_q <= 1'b0;
         ferr_q    <= RST_ERR_OUT;
         internal_error_out_q    <= RST_INTERNAL_ERROR_OUT;
         shut_q    <= 1'b0;
         hit_q     <= RST_SNOOP;
         snoop_hit_modified_q    <= RST_SNOOP;
         srv_q     <= 1'b0;
         rest_q    <= 1'b0;
         pc_q      <= '0;
         rst_prev_q <= 1'b0;
      end else begin
         fp_pend_q <= fp_pend_d;
         ferr_q    <= ferr_d;
         internal_error_out_q    <= internal_error_out_q | i_internal_error;           // RULE5 RULE6
         // one shutdown request at the first internal error after reset
         shut_q    <= (i_internal_error & ~internal_error_out_q)          // RULE7
                      | (shut_q & ~i_shutdown_ack);
         // snoops are answered in every init state
         hit_q     <= hit_d;                                // RULE14
         snoop_hit_modified_q    <= snoop_hit_modified_d;
         srv_q     <= i_snoop_req;                          // RULE14
         rest_q    <= (st_q == EIS_HOLD) & ~init_s;         // RULE13
         if ((st_q == EIS_HOLD) && !init_s) begin
            pc_q <= i_reset_vector;                         // RULE13
         end
         rst_prev_q <= 1'b1;
      end
   end

   // strap caught by the first clocked edge after reset release
   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         bist_q <= 1'b0;
      end else if (!rst_prev_q) begin
         bist_q <= init_s;                                  // RULE16
      end
   end

   assign o_fp_error_break_event_out = ferr_q;
   assign o_internal_error_out       = internal_error_out_q;
   assign o_shutdown_req             = shut_q;
   assign o_fp_exception             = take_exc;
   assign o_fp_continue              = go_on;
   assign o_snoop_hit                = hit_q;
   assign o_snoop_hit_modified       = snoop_hit_modified_q;
   assign o_snoop_stall_seen         = stall_in;
   assign o_snoop_serviced           = srv_q;
   assign o_init_busy                = (st_q != EIS_RUN);
   assign o_restart                  = rest_q;
   assign o_restart_pc               = pc_q;
   assign o_bist_run                 = bist_q;
endmodule

// ===== eis_top_properties.sv
module eis_top_properties (
   // watched ports
   input wire logic i_sys_clk, i_nrst, i_internal_error, i_snoop_req,
   input wire logic i_snoop_stall_need, i_snoop_hit_in, i_break_pending,
   input wire logic i_snoop_hit_modified_in, i_stop_clock_request,
   input wire logic i_fp_error, i_fp_error_masked, o_fp_error_break_event_out,
   input wire logic o_internal_error_out, o_shutdown_req, o_snoop_serviced,
   input wire logic o_snoop_hit, o_snoop_hit_modified, o_snoop_stall_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   // five cycles so the pin has passed the synchroniser
   sequence s_stp; i_stop_clock_request[*5]; endsequence
   sequence s_run; !i_stop_clock_request[*5]; endsequence
   sequence s_brk; i_break_pending[*2]; endsequence
   property p_ie; i_internal_error |=> o_internal_error_out; endproperty
   a_ie: assert property (p_ie) else $error("internal_error_out late");
   property p_ih; o_internal_error_out |=> o_internal_error_out; endproperty
   a_ih: assert property (p_ih) else $error("internal_error_out dropped");
   property p_sd; $rose(o_internal_error_out) |-> o_shutdown_req; endproperty
   a_sd: assert property (p_sd) else $error("no shutdown");
   property p_st; i_snoop_req && i_snoop_stall_need |=>
      o_snoop_hit && o_snoop_hit_modified; endproperty
   a_st: assert property (p_st) else $error("stall pair");
   property p_sv; i_snoop_req |=> o_snoop_serviced; endproperty
   a_sv: assert property (p_sv) else $error("snoop lost");
   property p_xs; o_snoop_stall_seen ==
      (i_snoop_hit_in && i_snoop_hit_modified_in); endproperty
   a_xs: assert property (p_xs) else $error("stall seen");
   property p_fe; s_run ##0 (i_fp_error && !i_fp_error_masked) |->
      ##2 o_fp_error_break_event_out; endproperty
   a_fe: assert property (p_fe) else $error("fp error");
   property p_pb; s_stp ##0 s_brk |=> o_fp_error_break_event_out; endproperty
   a_pb: assert property (p_pb) else $error("break");
   property p_pn; s_stp ##0 !i_break_pending |=>
      !o_fp_error_break_event_out; endproperty
   a_pn: assert property (p_pn) else $error("no break");
endmodule
bind eis_top eis_top_properties i_eis_top_properties (.*);

// ===== eis_top_tb.sv
module eis_top_tb;
   import eis_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_stop_clock_request = 1'b0;
   logic i_ignore_numeric_error_in = 1'b0, i_soft_init = 1'b0, stall = 1'b0;
   logic i_fp_error = 1'b0, i_fp_error_masked = 1'b0, i_fp_error_clear = 1'b0;
   logic i_break_pending = 1'b0, i_internal_error = 1'b0, i_reg_we = 1'b0;
   logic i_numeric_error_enable_bit = 1'b0, i_fp_noncontrol_issue = 1'b0;
   logic i_snoop_req = 1'b0, i_snoop_stall_need = 1'b0, i_snoop_hit = 1'b0;
   logic i_snoop_hit_modified = 1'b0, i_shutdown_ack, i_snoop_hit_in;
   logic i_snoop_hit_modified_in, o_fp_error_break_event_out, o_restart;
   logic o_internal_error_out, o_shutdown_req, o_fp_exception, o_fp_continue;
   logic o_snoop_hit, o_snoop_hit_modified, o_snoop_stall_seen, o_bist_run;
   logic o_snoop_serviced, o_init_busy;
   logic [2:0] i_reg_sel = 3'h0;
   logic [3:0] dly = 4'h0;
   logic [REG_W-1:0] i_reset_vector = 32'h0000f0f0, i_reg_wdata = 32'h5a5a0001;
   logic [REG_W-1:0] o_restart_pc;
   logic [INT_REGS*REG_W-1:0] o_int_regs;
   int num_errors = 0, n_compared = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   eis_top i_eis_top (.*);
   eis_partner i_eis_partner (.i_sys_clk, .i_shutdown_req(o_shutdown_req),
      .i_stall_cmd(stall), .i_ack_delay(dly), .o_shutdown_ack(i_shutdown_ack),
      .o_hit(i_snoop_hit_in), .o_hit_modified(i_snoop_hit_modified_in));
   task automatic chk(string nm, logic [255:0] exp, logic [255:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge i_sys_clk);
   endtask
   // outputs are judged at the falling edge, clear of input updates
   task automatic look;
      @(negedge i_sys_clk);
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic t_internal_error_out(logic [3:0] d);
      dly <= d;
      i_internal_error <= 1'b1;
      cyc(1);
      i_internal_error <= 1'b0;
      look;
      chk("internal_error_out", 2'h3, {o_internal_error_out, o_shutdown_req});
      cyc(d + 4);
      look;
      chk("internal_error_out", 2'h2, {o_internal_error_out, o_shutdown_req});
      $display("internal_error_out done");
   endtask
   task automatic t_snoop;
      i_snoop_stall_need <= 1'b1;
      stall <= 1'b1;
      i_snoop_req <= 1'b1;
      cyc(1);
      i_snoop_req <= 1'b0;
      look;
      chk("hit", 3'h7, {o_snoop_hit, o_snoop_hit_modified, o_snoop_stall_seen});
      cyc(1);
      stall <= 1'b0;
      look;
      chk("stall", 3'h0, {o_snoop_hit, o_snoop_hit_modified, o_snoop_stall_seen});
      $display("snoop done");
   endtask
   task automatic fp_issue(logic exc);
      i_fp_error <= 1'b1;
      cyc(1);
      i_fp_error <= 1'b0;
      cyc(1);
      look;
      chk("fperr", 1'b1, o_fp_error_break_event_out);
      cyc(1);
      i_fp_noncontrol_issue <= 1'b1;
      look;
      chk("exc", {exc, !exc}, {o_fp_exception, o_fp_continue});
      cyc(1);
      i_fp_noncontrol_issue <= 1'b0;
   endtask
   task automatic t_fp;
      i_fp_error_masked <= 1'b1;
      i_fp_error <= 1'b1;
      cyc(1);
      i_fp_error <= 1'b0;
      i_fp_error_masked <= 1'b0;
      cyc(2);
      look;
      chk("masked", 1'b0, o_fp_error_break_event_out);
      fp_issue(1'b1);
      i_ignore_numeric_error_in <= 1'b1;
      i_numeric_error_enable_bit <= 1'b1;
      cyc(4);
      fp_issue(1'b1);
      i_numeric_error_enable_bit <= 1'b0;
      fp_issue(1'b0);
      i_ignore_numeric_error_in <= 1'b0;
      i_stop_clock_request <= 1'b1;
      cyc(6);
      look;
      chk("pbe", 1'b0, o_fp_error_break_event_out);
      @(posedge i_sys_clk);
      i_break_pending <= 1'b1;
      cyc(2);
      look;
      chk("pbe", 1'b1, o_fp_error_break_event_out);
      @(posedge i_sys_clk);
      i_stop_clock_request <= 1'b0;
      i_break_pending <= 1'b0;
      cyc(6);
      look;
      chk("fperr", 1'b1, o_fp_error_break_event_out);
      @(posedge i_sys_clk);
      i_fp_error_clear <= 1'b1;
      cyc(1);
      i_fp_error_clear <= 1'b0;
      look;
      chk("fpclr", 1'b0, o_fp_error_break_event_out);
      $display("fp done");
   endtask
   task automatic t_init;
      i_reg_we <= 1'b1;
      cyc(1);
      i_reg_we <= 1'b0;
      look;
      chk("reg", i_reg_wdata, o_int_regs[REG_W-1:0]);
      cyc(1);
      i_soft_init <= 1'b1;
      cyc(4);
      i_snoop_req <= 1'b1;
      cyc(1);
      i_snoop_req <= 1'b0;
      look;
      chk("snoop", 1'b1, o_snoop_serviced);
      cyc(8);
      look;
      chk("regs", 1'b1, o_int_regs == '0 && o_init_busy);
      @(posedge i_sys_clk);
      i_soft_init <= 1'b0;
      repeat (12) if (o_restart !== 1'b1) look;
      chk("restart", 1'b1, o_restart);
      chk("pc", i_reset_vector, o_restart_pc);
      $display("init done");
   endtask
   task automatic t_bist;
      i_nrst <= 1'b0;
      i_soft_init <= 1'b1;
      cyc(4);
      look;
      chk("internal_error_out", 1'b0, o_internal_error_out);
      @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      cyc(2);
      i_soft_init <= 1'b0;
      look;
      chk("bist", 1'b1, o_bist_run);
      cyc(14);
      $display("bist done");
   endtask
   initial begin
      cyc(4);
      i_nrst <= 1'b1;
      cyc(3);
      t_internal_error_out(4'h0);
      t_snoop;
      t_fp;
      t_init;
      t_bist;
      t_internal_error_out(4'h5);
      end_sim;
   end
   initial begin
      cyc(2000);
      num_errors++;
      end_sim;
   end
endmodule
